// ==== rtl/itl_cnt_latch.sv ====
// Per-counter output latch, status latch and byte sequencer
`timescale 1ns/10ps
`default_nettype none
module itl_cnt_latch #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [CNT_W-1:0] live_cnt,
  input wire logic [7:0] status_in,
  input wire logic [1:0] rw_fmt,
  input wire logic lat_cnt,
  input wire logic lat_sts,
  input wire logic prog,
  input wire logic rd,
  output logic [7:0] rd_byte,
  output logic cnt_held_ff,
  output logic sts_held_ff
);
  import itl_pkg::*;

  logic [CNT_W-1:0] cnt_hold_ff, nxt_cnt_hold;
  logic [7:0] sts_hold_ff, nxt_sts_hold;
  logic nxt_cnt_held, nxt_sts_held;
  logic msb_next_ff, nxt_msb_next;

  // ----------------------------------------------------------------
  // Read data and next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cnt_hold = cnt_hold_ff;
    nxt_sts_hold = sts_hold_ff;
    nxt_cnt_held = cnt_held_ff;
    nxt_sts_held = sts_held_ff;
    nxt_msb_next = msb_next_ff;
    if (sts_held_ff) begin
      rd_byte = sts_hold_ff;
    end else begin
      rd_byte = itl_byte_pick(cnt_held_ff ? cnt_hold_ff : live_cnt, rw_fmt, msb_next_ff);
    end
    if (rd) begin
      if (sts_held_ff) begin
        nxt_sts_held = 1'b0;
      end else if (rw_fmt == ITL_RW_BOTH && !msb_next_ff) begin
        nxt_msb_next = 1'b1;
      end else begin
        nxt_msb_next = 1'b0;
        nxt_cnt_held = 1'b0;
      end
    end
    if (prog) begin
      nxt_msb_next = 1'b0;
      nxt_cnt_held = 1'b0;
      nxt_sts_held = 1'b0;
    end
    if (lat_cnt && !nxt_cnt_held) begin
      nxt_cnt_hold = live_cnt;
      nxt_cnt_held = 1'b1;
    end
    if (lat_sts && !nxt_sts_held) begin
      nxt_sts_hold = status_in;
      nxt_sts_held = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_hold_ff <= '0;
      sts_hold_ff <= ITL_BYTE_RST;
      cnt_held_ff <= 1'b0;
      sts_held_ff <= 1'b0;
      msb_next_ff <= 1'b0;
    end else begin
      cnt_hold_ff <= nxt_cnt_hold;
      sts_hold_ff <= nxt_sts_hold;
      cnt_held_ff <= nxt_cnt_held;
      sts_held_ff <= nxt_sts_held;
      msb_next_ff <= nxt_msb_next;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/itl_latch_top.sv ====
// Command decode and read-back for three interval timer counters
`timescale 1ns/10ps
`default_nettype none
module itl_latch_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_data,
  input wire logic [itl_pkg::ITL_NUM_CNT-1:0] rd_stb,
  input wire logic [itl_pkg::ITL_CNT_W-1:0] live_cnt0,
  input wire logic [itl_pkg::ITL_CNT_W-1:0] live_cnt1,
  input wire logic [itl_pkg::ITL_CNT_W-1:0] live_cnt2,
  input wire logic [itl_pkg::ITL_CFG_W-1:0] cfg0,
  input wire logic [itl_pkg::ITL_CFG_W-1:0] cfg1,
  input wire logic [itl_pkg::ITL_CFG_W-1:0] cfg2,
  input wire logic [itl_pkg::ITL_NUM_CNT-1:0] out_lvl,
  input wire logic [itl_pkg::ITL_NUM_CNT-1:0] null_cnt,
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic [itl_pkg::ITL_NUM_CNT-1:0] cnt_held,
  output logic [itl_pkg::ITL_NUM_CNT-1:0] sts_held
);
  import itl_pkg::*;

  logic [ITL_CNT_W-1:0] live [ITL_NUM_CNT];
  logic [ITL_CFG_W-1:0] cfg [ITL_NUM_CNT];
  logic [7:0] status [ITL_NUM_CNT];
  logic [7:0] rd_byte [ITL_NUM_CNT];
  logic [ITL_NUM_CNT-1:0] lat_cnt, lat_sts, prog;
  logic is_rb, is_latch;
  logic [1:0] sel;
  logic [7:0] nxt_rd_data;
  logic nxt_rd_valid;

  assign live[0] = live_cnt0;
  assign live[1] = live_cnt1;
  assign live[2] = live_cnt2;
  assign cfg[0] = cfg0;
  assign cfg[1] = cfg1;
  assign cfg[2] = cfg2;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign sel = cmd_data[ITL_SEL_HI:ITL_SEL_LO];
  assign is_rb = cmd_wr && sel == ITL_SEL_RB;
  assign is_latch = cmd_wr && !is_rb && cmd_data[ITL_RW_HI:ITL_RW_LO] == ITL_RW_LATCH;

  always_comb begin
    for (int i = 0; i < ITL_NUM_CNT; i++) begin
      status[i] = {out_lvl[i], null_cnt[i], cfg[i]};
      lat_cnt[i] = (is_rb && cmd_data[ITL_RB_CNT_BIT] && cmd_data[ITL_RB_SEL_LO + i])
                   || (is_latch && sel == i[1:0]);
      lat_sts[i] = is_rb && cmd_data[ITL_RB_STS_BIT] && cmd_data[ITL_RB_SEL_LO + i];
      prog[i] = cmd_wr && !is_rb && !is_latch && sel == i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Counter latches
  // ----------------------------------------------------------------
  for (genvar g = 0; g < ITL_NUM_CNT; g++) begin : g_cnt
    itl_cnt_latch #(
      .CNT_W(ITL_CNT_W)
    ) u_latch (
      .clk(clk),
      .rst_b(rst_b),
      .live_cnt(live[g]),
      .status_in(status[g]),
      .rw_fmt(cfg[g][ITL_CFG_RW_LO +: 2]),
      .lat_cnt(lat_cnt[g]),
      .lat_sts(lat_sts[g]),
      .prog(prog[g]),
      .rd(rd_stb[g]),
      .rd_byte(rd_byte[g]),
      .cnt_held_ff(cnt_held[g]),
      .sts_held_ff(sts_held[g])
    );
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rd_data = ITL_BYTE_RST;
    nxt_rd_valid = |rd_stb;
    for (int i = ITL_NUM_CNT - 1; i >= 0; i--) begin
      if (rd_stb[i]) begin
        nxt_rd_data = rd_byte[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= ITL_BYTE_RST;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_idle;
    !cmd_wr && rd_stb == 3'h0;
  endsequence

  sequence s_rb_both0;
    cmd_wr && cmd_data == 8'hf2 && !cnt_held[0] && !sts_held[0] && !rd_stb[0];
  endsequence

  sequence s_cnt1_lsb;
    cmd_wr && (cmd_data[7:4] == 4'h4 || (cmd_data[7:4] == 4'he && cmd_data[2]))
      && !cnt_held[1] && !sts_held[1] && !rd_stb[1]
      && cfg1[ITL_CFG_RW_LO +: 2] == ITL_RW_LSB;
  endsequence

  sequence s_latch0_both;
    cmd_wr && cmd_data[7:4] == 4'h0 && !cnt_held[0] && !sts_held[0] && !rd_stb[0]
      && cfg0[5:4] == ITL_RW_BOTH;
  endsequence

  AST_RB_CNT: assert property (cmd_wr && cmd_data[7:5] == 3'h7 && cmd_data[1]
    && !rd_stb[0] |=> cnt_held[0]) else $error("read-back did not latch count");

  AST_RB_STS: assert property (cmd_wr && cmd_data[7:6] == ITL_SEL_RB && !rd_stb[1]
    && !sts_held[1] |=> sts_held[1] == $past(cmd_data[4] && cmd_data[2]))
    else $error("status latch mismatch");

  AST_RB_UNSEL: assert property (cmd_wr && cmd_data[7:6] == ITL_SEL_RB
    && !cmd_data[3] && !cnt_held[2] |=> !cnt_held[2])
    else $error("unselected counter latched");

  AST_RB_ALL: assert property (cmd_wr && cmd_data[7:5] == 3'h7
    && cmd_data[3:1] == 3'h7 && rd_stb == 3'h0 |=> cnt_held == 3'h7)
    else $error("read-back missed a counter");

  AST_LATCH_SEL: assert property (cmd_wr && cmd_data[7:4] == 4'h4 && !rd_stb[1]
    |=> cnt_held[1]) else $error("latch command missed counter 1");

  AST_LATCH_SEL2: assert property (cmd_wr && cmd_data[7:4] == 4'h8 && !rd_stb[2]
    |=> cnt_held[2]) else $error("latch command missed counter 2");

  AST_LATCH_NO_STS: assert property (cmd_wr && cmd_data[7:4] == 4'h0
    && !rd_stb[0] && !sts_held[0] |=> !sts_held[0] && cnt_held[0])
    else $error("latch command misdecoded");

  AST_SNAP: assert property (s_cnt1_lsb ##1 s_idle
    ##1 (rd_stb == 3'h2 && !cmd_wr)
    |=> rd_valid_ff && rd_data_ff == $past(live_cnt1[7:0], 3))
    else $error("latched count differs from snapshot");

  AST_IGNORE: assert property (cnt_held[0] && !rd_stb[0] && !prog[0] && lat_cnt[0]
    |=> cnt_held[0]) else $error("held latch disturbed");

  AST_STS_FIRST: assert property (s_rb_both0 ##1 s_idle
    ##1 (rd_stb == 3'h1 && !cmd_wr)
    |=> rd_data_ff == $past(status[0], 3) && cnt_held[0] && !sts_held[0])
    else $error("status not returned first");

  AST_STS_BITS: assert property (s_rb_both0 ##1 s_idle
    ##1 (rd_stb == 3'h1 && !cmd_wr)
    |=> rd_data_ff[7:6] == $past({out_lvl[0], null_cnt[0]}, 3))
    else $error("status level bits wrong");

  AST_TWO_BYTE: assert property (s_latch0_both ##1 s_idle
    ##1 (rd_stb == 3'h1 && !cmd_wr) ##1 s_idle
    ##1 (rd_stb == 3'h2 && !cmd_wr) ##1 s_idle
    ##1 (rd_stb == 3'h1 && !cmd_wr)
    |=> rd_data_ff == $past(live_cnt0[15:8], 7) && !cnt_held[0])
    else $error("two-byte latched read broken");

  AST_PROG_CLR: assert property (cmd_wr && cmd_data[7:6] == 2'h2
    && cmd_data[5:4] != ITL_RW_LATCH |=> !cnt_held[2] && !sts_held[2])
    else $error("mode write left a latch");

  AST_RELEASE: assert property (cnt_held[1] && !sts_held[1] && rd_stb[1]
    && !lat_cnt[1] && cfg1[ITL_CFG_RW_LO +: 2] == ITL_RW_LSB |=> !cnt_held[1])
    else $error("latch not released");

  AST_RD_VALID: assert property (|rd_stb
    |=> rd_valid_ff ##1 (rd_valid_ff == $past(|rd_stb)))
    else $error("read not answered");

  // idle cycle returns the port to zero
  AST_RD_IDLE: assert property (rd_stb == 3'h0
    |=> !rd_valid_ff && rd_data_ff == ITL_BYTE_RST)
    else $error("read port not idle");

endmodule
`default_nettype wire

// ==== rtl/itl_pkg.sv ====
// Shared constants for the interval timer latch and read-back logic
package itl_pkg;

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int ITL_NUM_CNT = 3;
  localparam int ITL_CNT_W = 16;
  localparam int ITL_CFG_W = 6;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  localparam int ITL_SEL_HI = 7;
  localparam int ITL_SEL_LO = 6;
  localparam int ITL_RW_HI = 5;
  localparam int ITL_RW_LO = 4;
  localparam int ITL_RB_CNT_BIT = 5;
  localparam int ITL_RB_STS_BIT = 4;
  localparam int ITL_RB_SEL_LO = 1;
  localparam logic [1:0] ITL_SEL_RB = 2'h3;

  // ----------------------------------------------------------------
  // Read/write format codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ITL_RW_LATCH = 2'h0;
  localparam logic [1:0] ITL_RW_LSB = 2'h1;
  localparam logic [1:0] ITL_RW_MSB = 2'h2;
  localparam logic [1:0] ITL_RW_BOTH = 2'h3;
  localparam int ITL_CFG_RW_LO = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ITL_BYTE_RST = 8'h00;
  localparam logic [15:0] ITL_CNT_RST = 16'h0000;

  // Picks the byte of a count that the format and byte phase call for
  function automatic logic [7:0] itl_byte_pick(input logic [15:0] src,
                                               input logic [1:0] fmt,
                                               input logic msb_next);
    logic [7:0] res;
    res = src[7:0];
    if (fmt == ITL_RW_MSB || (fmt == ITL_RW_BOTH && msb_next)) begin
      res = src[15:8];
    end
    return res;
  endfunction

endpackage

// ==== testbench/interval_timer_latch_readback_tb_top.sv ====
// Self-checking bench for the timer latch and read-back block
`timescale 1ns/10ps
`default_nettype none
module interval_timer_latch_readback_tb_top;
  import itl_pkg::*;
  logic clk, rst_b, cmd_wr, rd_valid_ff;
  logic [7:0] cmd_data, rd_data_ff;
  logic [2:0] rd_stb, out_lvl, null_cnt, cnt_held, sts_held;
  logic [15:0] live [3];
  logic [15:0] snap [3];
  logic [5:0] cfg [3];
  logic [7:0] stsnap [3];
  logic [7:0] exp_q [$];
  int mismatches, checks, seed;

  itl_host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .rd_stb(rd_stb));
  itl_latch_top dut (.clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .rd_stb(rd_stb), .live_cnt0(live[0]), .live_cnt1(live[1]), .live_cnt2(live[2]),
    .cfg0(cfg[0]), .cfg1(cfg[1]), .cfg2(cfg[2]), .out_lvl(out_lvl), .null_cnt(null_cnt),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .cnt_held(cnt_held),
    .sts_held(sts_held));

  // ----------------------------------------------------------------
  // Clock, counting elements, checks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) live[i] <= live[i] - 16'(i + 1);
  end

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_flags(input logic [2:0] ec, input logic [2:0] es);
    #1;
    checks++;
    if ({cnt_held, sts_held} !== {ec, es}) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, {ec, es}, {cnt_held, sts_held});
    end
  endtask

  always @(posedge clk) begin
    if (rd_valid_ff === 1'b1) begin
      if (exp_q.size() == 0) begin
        checks++;
        mismatches++;
        $display("BAD t=%0t exp=%h got=%h", $time, 8'h00, rd_data_ff);
      end else chk_byte(exp_q.pop_front(), rd_data_ff);
    end
  end

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  task automatic cmd(input logic [7:0] d);
    host.wr_cmd(d);
    for (int i = 0; i < 3; i++) begin
      snap[i] = live[i];
      stsnap[i] = {out_lvl[i], null_cnt[i], cfg[i]};
    end
    out_lvl <= 3'($random(seed));
    null_cnt <= 3'($random(seed));
  endtask

  task automatic rd_cnt(input int i, input logic [15:0] v);
    if (cfg[i][5:4] != ITL_RW_MSB) begin
      exp_q.push_back(v[7:0]);
      host.rd(i);
    end
    if (cfg[i][5:4] != ITL_RW_LSB) begin
      exp_q.push_back(v[15:8]);
      host.rd(i);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] first;
    int n;
    seed = 40654;
    mismatches = 0;
    checks = 0;
    rst_b = 1'b0;
    out_lvl = 3'($random(seed));
    null_cnt = 3'($random(seed));
    for (int i = 0; i < 3; i++) begin
      live[i] = 16'($random(seed));
      cfg[i] = {(i == 0) ? ITL_RW_BOTH : (i == 1) ? ITL_RW_LSB : ITL_RW_MSB,
                4'($random(seed))};
    end
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cmd({2'(i), ITL_RW_LATCH, 4'h0});
      first = snap[i];
      chk_flags(3'h1 << i, 3'h0);
      repeat (3) @(posedge clk);
      cmd({2'(i), ITL_RW_LATCH, 4'h0});
      rd_cnt(i, first);
      chk_flags(3'h0, 3'h0);
    end
    $display("test counter latch done");
    for (int k = 1; k < 4; k++) begin
      for (int m = 1; m < 8; m++) begin
        cmd({ITL_SEL_RB, 2'(k), 3'(m), 1'b0});
        chk_flags(k[1] ? 3'(m) : 3'h0, k[0] ? 3'(m) : 3'h0);
        for (int i = 0; i < 3; i++) begin
          if (m[i]) begin
            if (k[0]) begin
              exp_q.push_back(stsnap[i]);
              host.rd(i);
            end
            if (k[1]) rd_cnt(i, snap[i]);
          end
        end
        chk_flags(3'h0, 3'h0);
      end
    end
    $display("test read-back done");
    // Latched two-byte count split by a live read of another counter
    cmd(8'h00);
    first = snap[0];
    exp_q.push_back(first[7:0]);
    host.rd(0);
    host.rd(1);
    exp_q.push_back(live[1][7:0]);
    exp_q.push_back(first[15:8]);
    host.rd(0);
    chk_flags(3'h0, 3'h0);
    // Read-back count of counters 0 and 1, programming in between
    cmd(8'he6);
    first = snap[0];
    exp_q.push_back(first[7:0]);
    host.rd(0);
    rd_cnt(1, snap[1]);
    cmd({2'h2, ITL_RW_MSB, 4'h0});
    exp_q.push_back(first[15:8]);
    host.rd(0);
    chk_flags(3'h0, 3'h0);
    host.rd(1);
    exp_q.push_back(live[1][7:0]);
    $display("test byte phase done");
    n = 0;
    while (exp_q.size() != 0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0) mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== testbench/itl_host_model.sv ====
// Host model issuing command word writes and data port reads
`timescale 1ns/10ps
`default_nettype none
module itl_host_model (
  input wire logic clk,
  output logic cmd_wr,
  output logic [7:0] cmd_data,
  output logic [itl_pkg::ITL_NUM_CNT-1:0] rd_stb
);
  import itl_pkg::*;

  initial begin
    cmd_wr = 1'b0;
    cmd_data = 8'h00;
    rd_stb = '0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // command write, low bit zero
  task automatic wr_cmd(input logic [7:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_data <= {d[7:1], 1'b0};
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_data <= ~{d[7:1], 1'b0};
  endtask

  // single read, caller keeps byte order
  task automatic rd(input int i);
    @(posedge clk);
    rd_stb <= ITL_NUM_CNT'(1) << i;
    @(posedge clk);
    rd_stb <= '0;
  endtask
endmodule
`default_nettype wire
